//--- src/tdc_transmitter_driver_config.sv
// register bank and pin logic of the two antenna drivers, reached over axi4-lite
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
module tdc_transmitter_driver_config (
  input  wire logic             aclk,                     // system clock, 40 MHz
  input  wire logic             aresetn,                  // synchronous reset, low
  input  wire logic [7:0]       s_axi_awaddr,             // write address
  input  wire logic [2:0]       s_axi_awprot,             // write protection, unused
  input  wire logic             s_axi_awvalid,            // write address valid
  output logic                  s_axi_awready,            // write address ready
  input  wire logic [31:0]      s_axi_wdata,              // write data
  input  wire logic [3:0]       s_axi_wstrb,              // write byte strobes
  input  wire logic             s_axi_wvalid,             // write data valid
  output logic                  s_axi_wready,             // write data ready
  output logic [1:0]            s_axi_bresp,              // write response
  output logic                  s_axi_bvalid,             // write response valid
  input  wire logic             s_axi_bready,             // write response ready
  input  wire logic [7:0]       s_axi_araddr,             // read address
  input  wire logic [2:0]       s_axi_arprot,             // read protection, unused
  input  wire logic             s_axi_arvalid,            // read address valid
  output logic                  s_axi_arready,            // read address ready
  output logic [31:0]           s_axi_rdata,              // read data
  output logic [1:0]            s_axi_rresp,              // read response
  output logic                  s_axi_rvalid,             // read data valid
  input  wire logic             s_axi_rready,             // read data ready
  input  wire logic             carrier_clock_in,         // carrier, asynchronous
  input  wire logic             internal_envelope_signal, // envelope, same clock
  input  wire logic             external_signal_input,    // modulation pin, async
  output tdc_pkg::tdc_pin_t     first_driver_output,      // first driver pin
  output tdc_pkg::tdc_pin_t     second_driver_output,     // second driver pin
  output logic [1:0]            carrier_level_reduction,  // amplitude reduction step
  output logic                  carrier_max,              // carrier at full amplitude
  output logic [4:0]            residual_level,           // residual carrier setting
  output logic [3:0]            load_current_trim,        // expected load current
  output logic                  modulation_active,        // modulation incl. overshoot
  output logic                  overshoot_boost           // first overshoot window
);

  logic [7:0] pin_q;
  logic [7:0] amp_q;
  logic [7:0] con_q;
  logic [7:0] trim_q;

  logic        aw_full_q;
  logic        w_full_q;
  logic [7:0]  aw_addr_q;
  logic [7:0]  w_data_q;
  logic        w_strb_q;
  logic [1:0]  bresp_q;
  logic        bvalid_q;
  logic        awready_q;
  logic        wready_q;

  wire aw_hs    = s_axi_awvalid & awready_q;
  wire w_hs     = s_axi_wvalid & wready_q;
  wire do_write = aw_full_q & w_full_q & ~bvalid_q;
  wire aw_full_d = aw_hs | (aw_full_q & ~do_write);
  wire w_full_d  = w_hs | (w_full_q & ~do_write);

  wire wr_pin  = (aw_addr_q == tdc_pkg::ADR_PIN);
  wire wr_amp  = (aw_addr_q == tdc_pkg::ADR_AMP);
  wire wr_con  = (aw_addr_q == tdc_pkg::ADR_CON);
  wire wr_trim = (aw_addr_q == tdc_pkg::ADR_TRIM);
  wire wr_hit  = wr_pin | wr_amp | wr_con | wr_trim;
  wire wr_en   = do_write & w_strb_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 8'h00;
      w_strb_q  <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awready_q <= ~aw_full_d;
      wready_q  <= ~w_full_d;
      if (aw_hs) begin
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_hs) begin
        w_data_q <= s_axi_wdata[7:0];
        w_strb_q <= s_axi_wstrb[0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= tdc_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? tdc_pkg::RESP_OKAY : tdc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // reserved bits never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q  <= tdc_pkg::RST_PIN;
      amp_q  <= tdc_pkg::RST_AMP;
      con_q  <= tdc_pkg::RST_CON;
      trim_q <= tdc_pkg::RST_TRIM;
    end else if (wr_en) begin
      if (wr_pin)  pin_q  <= w_data_q & tdc_pkg::MASK_PIN;
      if (wr_amp)  amp_q  <= w_data_q & tdc_pkg::MASK_AMP;
      if (wr_con)  con_q  <= w_data_q;
      if (wr_trim) trim_q <= w_data_q;
    end
  end

  logic        arready_q;
  logic        rvalid_q;
  logic [7:0]  rdata_q;
  logic [1:0]  rresp_q;

  wire        ar_hs   = s_axi_arvalid & arready_q;
  wire [7:0]  rd_addr = {s_axi_araddr[7:2], 2'b00};
  wire        rd_pin  = (rd_addr == tdc_pkg::ADR_PIN);
  wire        rd_amp  = (rd_addr == tdc_pkg::ADR_AMP);
  wire        rd_con  = (rd_addr == tdc_pkg::ADR_CON);
  wire        rd_trim = (rd_addr == tdc_pkg::ADR_TRIM);
  wire        rd_hit  = rd_pin | rd_amp | rd_con | rd_trim;
  wire [7:0]  rd_mux  = ({8{rd_pin}} & pin_q) | ({8{rd_amp}} & amp_q)
                      | ({8{rd_con}} & con_q) | ({8{rd_trim}} & trim_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 8'h00;
      rresp_q   <= tdc_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_mux;
      rresp_q   <= rd_hit ? tdc_pkg::RESP_OKAY : tdc_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = {24'h000000, rdata_q};

  wire       inv2     = pin_q[tdc_pkg::PIN_INV2_BIT];
  wire       inv1     = pin_q[tdc_pkg::PIN_INV1_BIT];
  wire       drv_en   = pin_q[tdc_pkg::PIN_EN_BIT];
  wire [2:0] drv_mode = pin_q[tdc_pkg::PIN_MODE_LSB +: 3];
  wire [1:0] red_fld  = amp_q[tdc_pkg::AMP_RED_LSB +: 2];
  wire [4:0] res_fld  = amp_q[tdc_pkg::AMP_RES_LSB +: 5];
  wire [3:0] os2_len  = con_q[tdc_pkg::CON_OS2_LSB +: 4];
  wire       cw_max   = con_q[tdc_pkg::CON_MAX_BIT];
  wire       mod_inv  = con_q[tdc_pkg::CON_INV_BIT];
  wire [1:0] mod_src  = con_q[tdc_pkg::CON_SRC_LSB +: 2];
  wire [3:0] os1_val  = trim_q[tdc_pkg::TRIM_OS1_LSB +: 4];
  wire [3:0] ld_fld   = trim_q[tdc_pkg::TRIM_LD_LSB +: 4];

  // two flops before any logic reads an asynchronous pin
  logic carrier_s1_q;
  logic carrier_s2_q;
  logic carrier_s3_q;
  logic ext_s1_q;
  logic ext_s2_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carrier_s1_q <= 1'b0;
      carrier_s2_q <= 1'b0;
      carrier_s3_q <= 1'b0;
      ext_s1_q     <= 1'b0;
      ext_s2_q     <= 1'b0;
    end else begin
      carrier_s1_q <= carrier_clock_in;
      carrier_s2_q <= carrier_s1_q;
      carrier_s3_q <= carrier_s2_q;
      ext_s1_q     <= external_signal_input;
      ext_s2_q     <= ext_s1_q;
    end
  end

  wire carrier_edge = carrier_s2_q & ~carrier_s3_q;

  wire mod_valid = (mod_src == tdc_pkg::SRC_ENV) | (mod_src == tdc_pkg::SRC_EXT);
  wire mod_raw   = (mod_src == tdc_pkg::SRC_ENV) ? internal_envelope_signal
                 : (mod_src == tdc_pkg::SRC_EXT) ? ext_s2_q : 1'b0;
  wire mod_sig   = mod_valid & (mod_raw ^ mod_inv);

  // overshoot timers, counted in synchronised carrier edges
  logic       mod_prev_q;
  logic [3:0] t1_cnt_q;
  logic [3:0] t2_cnt_q;

  wire mod_rise = mod_sig & ~mod_prev_q;
  wire mod_fall = ~mod_sig & mod_prev_q;
  wire [3:0] t1_dec = (t1_cnt_q != 4'h0 && carrier_edge) ? t1_cnt_q - 4'h1 : t1_cnt_q;
  wire [3:0] t2_dec = (t2_cnt_q != 4'h0 && carrier_edge) ? t2_cnt_q - 4'h1 : t2_cnt_q;
  wire [3:0] t1_cnt_d = mod_rise ? os1_val : (mod_sig ? t1_dec : 4'h0);
  wire [3:0] t2_cnt_d = mod_fall ? os2_len : (mod_sig ? 4'h0 : t2_dec);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mod_prev_q <= 1'b0;
      t1_cnt_q   <= 4'h0;
      t2_cnt_q   <= 4'h0;
    end else begin
      mod_prev_q <= mod_sig;
      t1_cnt_q   <= t1_cnt_d;
      t2_cnt_q   <= t2_cnt_d;
    end
  end

  function automatic tdc_pkg::tdc_pin_t drive(input logic en, input logic [2:0] mode,
                                              input logic v);
    tdc_pkg::tdc_pin_t p;
    p = '{out: 1'b0, oe: 1'b0};
    if (en) begin
      unique case (mode)
        tdc_pkg::MODE_PUSHPULL: p = '{out: v, oe: 1'b1};
        tdc_pkg::MODE_OPENDRN:  p = '{out: 1'b0, oe: ~v};
        tdc_pkg::MODE_FIXLOW:   p = '{out: 1'b0, oe: 1'b1};
        tdc_pkg::MODE_FIXHIGH:  p = '{out: 1'b1, oe: 1'b1};
        default:                p = '{out: 1'b0, oe: 1'b0};
      endcase
    end
    return p;
  endfunction : drive

  wire               tx1_val = carrier_s2_q ^ inv1;
  wire               tx2_val = carrier_s2_q ^ inv2;
  tdc_pkg::tdc_pin_t tx1_d;
  tdc_pkg::tdc_pin_t tx2_d;
  tdc_pkg::tdc_pin_t tx1_q;
  tdc_pkg::tdc_pin_t tx2_q;
  assign tx1_d = drive(drv_en, drv_mode, tx1_val);
  assign tx2_d = drive(drv_en, drv_mode, tx2_val);

  logic [1:0] red_q;
  logic       max_q;
  logic [4:0] res_q;
  logic [3:0] ld_q;
  logic       mact_q;
  logic       boost_q;

  // outputs follow the registers one cycle after they change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx1_q   <= '{out: 1'b0, oe: 1'b0};
      tx2_q   <= '{out: 1'b0, oe: 1'b0};
      red_q   <= 2'h0;
      max_q   <= 1'b0;
      res_q   <= 5'h00;
      ld_q    <= 4'h0;
      mact_q  <= 1'b0;
      boost_q <= 1'b0;
    end else begin
      tx1_q   <= tx1_d;
      tx2_q   <= tx2_d;
      red_q   <= cw_max ? 2'h0 : red_fld;
      max_q   <= cw_max;
      res_q   <= res_fld;
      ld_q    <= ld_fld;
      mact_q  <= mod_sig | (t2_cnt_q != 4'h0);
      boost_q <= t1_cnt_q != 4'h0;
    end
  end

  assign first_driver_output     = tx1_q;
  assign second_driver_output    = tx2_q;
  assign carrier_level_reduction = red_q;
  assign carrier_max             = max_q;
  assign residual_level          = res_q;
  assign load_current_trim       = ld_q;
  assign modulation_active       = mact_q;
  assign overshoot_boost         = boost_q;

  enable_off_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !drv_en |=> !first_driver_output.oe && !second_driver_output.oe)
    else $error("driver drives while disabled");

  invert_two_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (drv_en && drv_mode == tdc_pkg::MODE_PUSHPULL)
    |=> second_driver_output.out == ($past(carrier_s2_q) ^ $past(inv2)))
    else $error("second driver polarity wrong");

  invert_one_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (drv_en && drv_mode == tdc_pkg::MODE_PUSHPULL)
    |=> first_driver_output.out == ($past(carrier_s2_q) ^ $past(inv1)))
    else $error("first driver polarity wrong");

  bad_mode_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (drv_mode == 3'h3 || drv_mode == 3'h4) |=> !first_driver_output.oe)
    else $error("unsupported mode drives pin");

  level_max_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cw_max |=> carrier_max && carrier_level_reduction == 2'h0)
    else $error("maximum carrier not applied");

  level_red_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !cw_max |=> carrier_level_reduction == $past(red_fld))
    else $error("level reduction not applied");

  no_mod_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    mod_src == tdc_pkg::SRC_NONE |-> !mod_sig)
    else $error("modulation without source");

  env_inv_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    mod_src == tdc_pkg::SRC_ENV |-> mod_sig == (internal_envelope_signal ^ mod_inv))
    else $error("envelope modulation wrong");

  os2_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (mod_fall && os2_len != 4'h0) |=> ##1 modulation_active)
    else $error("overshoot extension missing");

  os1_boost_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (mod_rise && os1_val != 4'h0) |=> ##1 overshoot_boost)
    else $error("first overshoot window missing");

  rsvd_zero_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    pin_q[5:4] == 2'h0 && amp_q[5] == 1'b0)
    else $error("reserved bit stored");

  cfg_next_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_en && wr_trim) |=> ##1 load_current_trim == $past(w_data_q[3:0], 2))
    else $error("setting late at output");

endmodule : tdc_transmitter_driver_config

//--- src/tdc_pkg.sv
// constants and types for the transmitter driver configuration bank
package tdc_pkg;

  // register indices and their byte addresses on the bus
  localparam logic [7:0] IDX_PIN  = 8'h28;
  localparam logic [7:0] IDX_AMP  = 8'h29;
  localparam logic [7:0] IDX_CON  = 8'h2A;
  localparam logic [7:0] IDX_TRIM = 8'h2B;
  localparam logic [7:0] ADR_PIN  = {IDX_PIN[5:0], 2'b00};
  localparam logic [7:0] ADR_AMP  = {IDX_AMP[5:0], 2'b00};
  localparam logic [7:0] ADR_CON  = {IDX_CON[5:0], 2'b00};
  localparam logic [7:0] ADR_TRIM = {IDX_TRIM[5:0], 2'b00};

  // values after reset
  localparam logic [7:0] RST_PIN  = 8'h00;
  localparam logic [7:0] RST_AMP  = 8'h00;
  localparam logic [7:0] RST_CON  = 8'h00;
  localparam logic [7:0] RST_TRIM = 8'h00;

  // writable bits; reserved bits are dropped
  localparam logic [7:0] MASK_PIN = 8'hCF;
  localparam logic [7:0] MASK_AMP = 8'hDF;

  // field positions
  localparam int PIN_INV2_BIT = 7;
  localparam int PIN_INV1_BIT = 6;
  localparam int PIN_EN_BIT   = 3;
  localparam int PIN_MODE_LSB = 0;
  localparam int AMP_RED_LSB  = 6;
  localparam int AMP_RES_LSB  = 0;
  localparam int CON_OS2_LSB  = 4;
  localparam int CON_MAX_BIT  = 3;
  localparam int CON_INV_BIT  = 2;
  localparam int CON_SRC_LSB  = 0;
  localparam int TRIM_OS1_LSB = 4;
  localparam int TRIM_LD_LSB  = 0;

  // driver output modes
  localparam logic [2:0] MODE_HIZ      = 3'h0;
  localparam logic [2:0] MODE_PUSHPULL = 3'h1;
  localparam logic [2:0] MODE_OPENDRN  = 3'h2;
  localparam logic [2:0] MODE_FIXLOW   = 3'h5;
  localparam logic [2:0] MODE_FIXHIGH  = 3'h6;

  // modulation sources
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_ENV  = 2'h1;
  localparam logic [1:0] SRC_EXT  = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic out;
    logic oe;
  } tdc_pin_t;

endpackage : tdc_pkg

//--- sim/tdc_antenna_model.sv
// antenna network model: resolves the level seen on each driver pin
`timescale 1ns/1ps
module tdc_antenna_model (
  input  wire logic              aclk,       // system clock
  input  wire tdc_pkg::tdc_pin_t first_pin,  // first driver pin
  input  wire tdc_pkg::tdc_pin_t second_pin, // second driver pin
  output logic                   tx1_level,  // level at first pin
  output logic                   tx2_level   // level at second pin
);
  logic l1_q = 1'b0;
  logic l2_q = 1'b0;
  // no pull on the network: a released pin wanders, so it never repeats a stale level
  assign tx1_level = first_pin.oe ? first_pin.out : ~l1_q;
  assign tx2_level = second_pin.oe ? second_pin.out : ~l2_q;
  always_ff @(posedge aclk) begin
    l1_q <= tx1_level;
    l2_q <= tx2_level;
  end
endmodule : tdc_antenna_model

//--- sim/tdc_testbench.sv
// self-checking bench for the transmitter driver configuration bank
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [7:0]        s_axi_awaddr = 8'h00;
  logic [7:0]        s_axi_araddr = 8'h00;
  logic [2:0]        s_axi_awprot = 3'h0;
  logic [2:0]        s_axi_arprot = 3'h0;
  logic              s_axi_awvalid = 1'b0;
  logic              s_axi_wvalid = 1'b0;
  logic              s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0;
  logic              s_axi_rready = 1'b0;
  logic [31:0]       s_axi_wdata = 32'h0;
  logic [3:0]        s_axi_wstrb = 4'h0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, carrier_level_reduction;
  logic [31:0]       s_axi_rdata;
  logic              carrier_clock_in = 1'b0;
  logic              internal_envelope_signal = 1'b0;
  logic              external_signal_input = 1'b0;
  tdc_pkg::tdc_pin_t first_driver_output, second_driver_output;
  logic              carrier_max, modulation_active, overshoot_boost, tx1_level, tx2_level;
  logic [4:0]        residual_level;
  logic [3:0]        load_current_trim;
  int                mismatches = 0;
  int                checks = 0;
  int                seed = 38;
  logic [7:0]        m [4];
  localparam logic [7:0] A [4] = '{tdc_pkg::ADR_PIN, tdc_pkg::ADR_AMP, tdc_pkg::ADR_CON,
                                   tdc_pkg::ADR_TRIM};
  localparam logic [7:0] MK [4] = '{8'hCF, 8'hDF, 8'hFF, 8'hFF};
  localparam logic [2:0] MD [5] = '{tdc_pkg::MODE_HIZ, tdc_pkg::MODE_PUSHPULL,
                                    tdc_pkg::MODE_OPENDRN, tdc_pkg::MODE_FIXLOW,
                                    tdc_pkg::MODE_FIXHIGH};
  localparam logic [1:0] OK = tdc_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = tdc_pkg::RESP_SLVERR;

  always #12.5 aclk = ~aclk;

  tdc_transmitter_driver_config dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .carrier_clock_in,
    .internal_envelope_signal, .external_signal_input, .first_driver_output,
    .second_driver_output, .carrier_level_reduction, .carrier_max, .residual_level,
    .load_current_trim, .modulation_active, .overshoot_boost);

  tdc_antenna_model ant_u (.aclk, .first_pin(first_driver_output),
    .second_pin(second_driver_output), .tx1_level, .tx2_level);

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er,
                    input logic [3:0] st);
    logic ad;
    logic dd;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    ad = 1'b0;
    dd = 1'b0;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (!ad && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!dd && s_axi_wready) begin
        dd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, {24'h000000, ed})
    `CHK(s_axi_rresp, er)
  endtask : rd

  task automatic put(input int i, input logic [7:0] d);
    wr(A[i], d, OK, 4'h1);
    m[i] = d & MK[i];
  endtask : put

  // n slow carrier periods of 8 clocks each, long enough for the synchroniser to follow
  task automatic spin(input int n);
    repeat (n) begin
      carrier_clock_in <= 1'b1;
      tick(4);
      carrier_clock_in <= 1'b0;
      tick(4);
    end
  endtask : spin

  function automatic logic [1:0] pexp(input logic [2:0] md, input logic en, input logic v);
    if (!en) return 2'b00;
    case (md)
      tdc_pkg::MODE_PUSHPULL: return {v, 1'b1};
      tdc_pkg::MODE_OPENDRN:  return {1'b0, ~v};
      tdc_pkg::MODE_FIXLOW:   return 2'b01;
      tdc_pkg::MODE_FIXHIGH:  return 2'b11;
      default:                return 2'b00;
    endcase
  endfunction : pexp

  // a pin in MODE_HIZ has no defined data bit, so only its enable is compared
  function automatic logic [1:0] seen(input tdc_pkg::tdc_pin_t p, input logic hz);
    return hz ? {1'b0, p.oe} : {p.out, p.oe};
  endfunction : seen

  function automatic logic mexp(input logic [1:0] s, input logic iv, input logic e, input logic x);
    case (s)
      2'h1:    return e ^ iv;
      2'h2:    return x ^ iv;
      default: return 1'b0;
    endcase
  endfunction : mexp

  task automatic done(input string s);
    $display("test %s finished, mismatches so far %0d", s, mismatches);
  endtask : done

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  initial begin
    tick(30000);
    mismatches++;
    conclude();
  end

  initial begin
    int i;
    int k;
    int n;
    logic [7:0] d;
    logic [2:0] md;
    logic [1:0] iv;
    logic ev;
    logic xv;
    tick(2);
    aresetn <= 1'b1;
    for (i = 0; i < 4; i++) begin
      m[i] = 8'h00;
      rd(A[i], 8'h00, OK);
    end
    put(0, 8'hFF);
    put(1, 8'hFF);
    rd(A[0], 8'hCF, OK);
    rd(A[1], 8'hDF, OK);
    wr(8'hB0, 8'h55, ERR, 4'h1);
    // lowest strobe clear: the write is answered but nothing is stored
    wr(A[2], 8'hFF, OK, 4'hE);
    rd(A[2], 8'h00, OK);
    rd(8'hB0, 8'h00, ERR);
    done("reset_reserved_unmapped");
    for (i = 0; i < 24; i++) begin
      k = $unsigned($random(seed)) % 4;
      d = 8'($random(seed));
      if (k == 0 && (d[2:0] == 3'h3 || d[2:0] == 3'h4)) d[2:0] = 3'h1;
      put(k, d);
      rd(A[k], m[k], OK);
      `CHK(carrier_max, m[2][3])
      `CHK(carrier_level_reduction, m[2][3] ? 2'h0 : m[1][7:6])
      `CHK(residual_level, m[1][4:0])
      `CHK(load_current_trim, m[3][3:0])
    end
    done("random_readback");
    for (i = 0; i < 40; i++) begin
      md = MD[i % 5];
      iv = 2'((i / 10) % 4);
      put(0, {iv, 2'b00, 1'((i / 5) % 2), md});
      for (k = 0; k < 2; k++) begin
        carrier_clock_in <= k[0];
        tick(6);
        `CHK(seen(first_driver_output, md == 3'h0), pexp(md, m[0][3], k[0] ^ iv[0]))
        `CHK(seen(second_driver_output, md == 3'h0), pexp(md, m[0][3], k[0] ^ iv[1]))
        if (m[0][3] && md == tdc_pkg::MODE_PUSHPULL) `CHK(tx2_level, k[0] ^ iv[1])
        if (m[0][3] && md == tdc_pkg::MODE_PUSHPULL) `CHK(tx1_level, k[0] ^ iv[0])
      end
    end
    done("driver_modes");
    put(2, 8'h00);
    spin(20);
    for (i = 0; i < 16; i++) begin
      ev = 1'($random(seed));
      xv = 1'($random(seed));
      put(2, {5'h00, i[2], i[1:0]});
      internal_envelope_signal <= ev;
      external_signal_input <= xv;
      tick(6);
      `CHK(modulation_active, mexp(i[1:0], i[2], ev, xv))
    end
    done("modulation_source");
    for (i = 0; i < 3; i++) begin
      n = (i == 0) ? 1 : (i == 1) ? 15 : $unsigned($random(seed)) % 13 + 2;
      put(2, {n[3:0], 4'h1});
      internal_envelope_signal <= 1'b1;
      tick(6);
      internal_envelope_signal <= 1'b0;
      tick(6);
      for (k = 1; k <= n; k++) begin
        spin(1);
        `CHK(modulation_active, 1'(k < n))
      end
    end
    done("second_overshoot");
    for (i = 0; i < 2; i++) begin
      n = i ? $unsigned($random(seed)) % 15 + 1 : 0;
      put(2, 8'h01);
      put(3, {n[3:0], 4'h0});
      internal_envelope_signal <= 1'b1;
      tick(6);
      `CHK(overshoot_boost, 1'(n != 0))
      internal_envelope_signal <= 1'b0;
      tick(6);
      `CHK(overshoot_boost, 1'b0)
    end
    done("first_overshoot");
    conclude();
  end
endmodule : testbench
